// ---- design/boi_consts.svh ----
`ifndef BOI_CONSTS_SVH
`define BOI_CONSTS_SVH

// ----------------------------------------
// Indirect window addresses in file space
// ----------------------------------------
`define BOI_IND0_ADDR 7'h00
`define BOI_IND1_ADDR 7'h01

// ----------------------------------------
// Pointer update select codes
// ----------------------------------------
`define BOI_MM_PRE_INC 2'b00
`define BOI_MM_PRE_DEC 2'b01
`define BOI_MM_POST_INC 2'b10
`define BOI_MM_POST_DEC 2'b11

// ----------------------------------------
// Destination select and bit positions
// ----------------------------------------
`define BOI_DEST_ACC 1'b0
`define BOI_DEST_FILE 1'b1
`define BOI_MSB 7
`define BOI_LSB 0

// ----------------------------------------
// Reset values and steps
// ----------------------------------------
`define BOI_BYTE_RST 8'h00
`define BOI_BYTE_ONE 8'h01
`define BOI_PTR_RST 16'h0000
`define BOI_PTR_STEP 16'h0001
`define BOI_FILE_ADDR_RST 7'h00
`define BOI_OFFSET_ZERO 6'h00
`define BOI_FLAG_RST 1'b0
`define BOI_SHIFT_STEP 1

`endif

// ---- design/boi_pkg.sv ----
package boi_pkg;

    // Operation selector presented with each instruction
    typedef enum logic [2:0] {
        BOI_OP_IDLE,
        BOI_OP_ADD_ONE_TO_OPERAND,
        BOI_OP_BITWISE_OR_ACCUMULATOR_OPERAND,
        BOI_OP_SHIFT_LEFT_LOGICAL,
        BOI_OP_SHIFT_RIGHT_LOGICAL,
        BOI_OP_COPY_OPERAND,
        BOI_OP_LOAD_VIA_POINTER
    } boi_op_t;

    typedef logic [15:0] boi_ptr_t;

endpackage : boi_pkg

// ---- design/boi_ptr_if.sv ----
`timescale 1ns/1ps
`default_nettype none

interface boi_ptr_if;
    import boi_pkg::*;
    logic sel;
    logic [1:0] pointer_update_select;
    logic rel_en;
    logic [5:0] rel_offset;
    logic upd_en;
    logic load_en;
    logic load_sel;
    boi_ptr_t load_val;
    boi_ptr_t eff_addr;
    boi_ptr_t ptr0;
    boi_ptr_t ptr1;

    modport exec (
        output sel, pointer_update_select, rel_en, rel_offset, upd_en, load_en, load_sel, load_val,
        input eff_addr, ptr0, ptr1
    );
    modport unit (
        input sel, pointer_update_select, rel_en, rel_offset, upd_en, load_en, load_sel, load_val,
        output eff_addr, ptr0, ptr1
    );
endinterface : boi_ptr_if

`default_nettype wire

// ---- design/boi_ptr_unit.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "boi_consts.svh"

module boi_ptr_unit (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Link to execution datapath
    boi_ptr_if.unit pif
);
    import boi_pkg::*;

    boi_ptr_t ptr_q [2];
    boi_ptr_t ptr_d [2];
    boi_ptr_t cur;
    boi_ptr_t offset_ext;
    logic is_dec;

    // ----------------------------------------
    // Address and pointer update
    // ----------------------------------------
    always_comb begin
        cur = pif.sel ? ptr_q[1] : ptr_q[0];
        // Signed cast sign-extends the offset to pointer width
        offset_ext = boi_ptr_t'($signed(pif.rel_offset));
        is_dec = (pif.pointer_update_select == `BOI_MM_PRE_DEC) ||
                 (pif.pointer_update_select == `BOI_MM_POST_DEC);
        if (pif.rel_en) begin
            pif.eff_addr = cur + offset_ext;
        end else if (pif.pointer_update_select == `BOI_MM_PRE_INC) begin
            pif.eff_addr = cur + `BOI_PTR_STEP;
        end else if (pif.pointer_update_select == `BOI_MM_PRE_DEC) begin
            pif.eff_addr = cur - `BOI_PTR_STEP;
        end else begin
            pif.eff_addr = cur;
        end
        ptr_d[0] = ptr_q[0];
        ptr_d[1] = ptr_q[1];
        // 16-bit arithmetic wraps at both ends by itself
        if (pif.upd_en) begin
            ptr_d[pif.sel] = is_dec ? cur - `BOI_PTR_STEP : cur + `BOI_PTR_STEP;
        end
        // A direct load beats a same-cycle auto update
        if (pif.load_en) begin
            ptr_d[pif.load_sel] = pif.load_val;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ptr_q[0] <= `BOI_PTR_RST;
            ptr_q[1] <= `BOI_PTR_RST;
        end else begin
            ptr_q[0] <= ptr_d[0];
            ptr_q[1] <= ptr_d[1];
        end
    end

    assign pif.ptr0 = ptr_q[0];
    assign pif.ptr1 = ptr_q[1];

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    ptr_wrap_step_a: assert property (
        pif.upd_en && !pif.load_en && !pif.sel |=>
            ptr_q[0] == ($past(is_dec) ? $past(ptr_q[0]) - `BOI_PTR_STEP : $past(ptr_q[0]) + `BOI_PTR_STEP))
        else $error("Pointer 0 step or wrap wrong");

    rel_addr_a: assert property (
        pif.rel_en |-> pif.eff_addr == ((pif.sel ? ptr_q[1] : ptr_q[0]) + boi_ptr_t'($signed(pif.rel_offset))))
        else $error("Relative address wrong");

    rel_hold_a: assert property (
        pif.rel_en && !pif.load_en && !pif.upd_en |=> $stable(ptr_q[0]) && $stable(ptr_q[1]))
        else $error("Pointer moved on relative access");

endmodule : boi_ptr_unit

`default_nettype wire

// ---- design/boi_exec.sv ----
// What this block does
// - Increment operand, result to destination, Z
// - Destination bit 0 accumulator, 1 operand
// - OR accumulator with operand, only Z
// - Left shift: bit7 to carry, zero in
// - Right shift: bit0 to carry, zero in
// - Copy operand to destination, set Z
// - Load byte through pointer into accumulator, Z
// - Address pointer+1, pointer-1, pointer (post modes), or pointer+offset
// - Mode 00/01/10/11: pre/post inc/dec
// - Pointer ends +1, -1, or unchanged
// - Window registers redirect through their pointer
// - Pointer wraps across 0000h and FFFFh
`timescale 1ns/1ps
`default_nettype none
`include "boi_consts.svh"

module boi_exec (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Instruction issue
    input wire logic op_valid,
    input wire boi_pkg::boi_op_t op_code,
    input wire logic [6:0] file_addr,
    input wire logic dest_sel,
    input wire logic ptr_sel,
    input wire logic [1:0] pointer_update_select,
    input wire logic rel_mode,
    input wire logic [5:0] rel_offset,
    // Operand sources, valid in the issue cycle
    input wire logic [7:0] file_rd_data,
    input wire logic [7:0] mem_rd_data,
    // Direct pointer load
    input wire logic ptr_load_en,
    input wire logic ptr_load_sel,
    input wire boi_pkg::boi_ptr_t ptr_load_val,
    // Memory address through pointer
    output boi_pkg::boi_ptr_t mem_rd_addr,
    // Write back
    output logic file_wr_en_q,
    output logic [6:0] file_wr_addr_q,
    output logic [7:0] file_wr_data_q,
    output logic mem_wr_en_q,
    output boi_pkg::boi_ptr_t mem_wr_addr_q,
    output logic [7:0] mem_wr_data_q,
    // Architectural state
    output logic [7:0] acc_q,
    output logic zero_q,
    output logic carry_q,
    output boi_pkg::boi_ptr_t ptr0_q,
    output boi_pkg::boi_ptr_t ptr1_q,
    output logic done_q
);
    import boi_pkg::*;

    boi_ptr_if pif ();

    boi_ptr_unit u_ptr (
        .clk(clk),
        .rst_n(rst_n),
        .pif(pif)
    );

    logic is_ind;
    logic is_load;
    logic [7:0] operand;
    logic [7:0] result;
    logic carry_new;
    logic carry_upd;
    logic writes;
    logic acc_d;

    logic [7:0] acc_d_v;
    logic zero_d;
    logic carry_d;
    logic file_wr_en_d;
    logic [6:0] file_wr_addr_d;
    logic [7:0] file_wr_data_d;
    logic mem_wr_en_d;
    boi_ptr_t mem_wr_addr_d;
    logic [7:0] mem_wr_data_d;

    // ----------------------------------------
    // Pointer request
    // ----------------------------------------
    always_comb begin
        is_ind = (file_addr == `BOI_IND0_ADDR) || (file_addr == `BOI_IND1_ADDR);
        is_load = (op_code == BOI_OP_LOAD_VIA_POINTER);
        // Plain window access uses the pointer as is, so it rides the offset path at zero
        pif.sel = is_load ? ptr_sel : (file_addr == `BOI_IND1_ADDR);
        pif.pointer_update_select = pointer_update_select;
        pif.rel_en = is_load ? rel_mode : 1'b1;
        pif.rel_offset = is_load ? rel_offset : `BOI_OFFSET_ZERO;
        pif.upd_en = op_valid && is_load && !rel_mode;
        pif.load_en = ptr_load_en;
        pif.load_sel = ptr_load_sel;
        pif.load_val = ptr_load_val;
    end

    assign mem_rd_addr = pif.eff_addr;
    assign ptr0_q = pif.ptr0;
    assign ptr1_q = pif.ptr1;

    // ----------------------------------------
    // Arithmetic and logic
    // ----------------------------------------
    always_comb begin
        operand = (is_ind || is_load) ? mem_rd_data : file_rd_data;
        result = operand;
        carry_new = carry_q;
        carry_upd = 1'b0;
        writes = op_valid;
        case (op_code)
            BOI_OP_ADD_ONE_TO_OPERAND: begin
                result = operand + `BOI_BYTE_ONE;
            end
            BOI_OP_BITWISE_OR_ACCUMULATOR_OPERAND: begin
                result = acc_q | operand;
            end
            BOI_OP_SHIFT_LEFT_LOGICAL: begin
                result = operand << `BOI_SHIFT_STEP;
                carry_new = operand[`BOI_MSB];
                carry_upd = 1'b1;
            end
            BOI_OP_SHIFT_RIGHT_LOGICAL: begin
                result = operand >> `BOI_SHIFT_STEP;
                carry_new = operand[`BOI_LSB];
                carry_upd = 1'b1;
            end
            BOI_OP_COPY_OPERAND: begin
                result = operand;
            end
            BOI_OP_LOAD_VIA_POINTER: begin
                result = mem_rd_data;
            end
            default: begin
                writes = 1'b0;
            end
        endcase
        acc_d = writes && (is_load || dest_sel == `BOI_DEST_ACC);
    end

    // ----------------------------------------
    // Commit, all in the issue cycle
    // ----------------------------------------
    always_comb begin
        acc_d_v = acc_d ? result : acc_q;
        zero_d = writes ? (result == `BOI_BYTE_RST) : zero_q;
        carry_d = (writes && carry_upd) ? carry_new : carry_q;
        file_wr_en_d = writes && !is_load && dest_sel == `BOI_DEST_FILE && !is_ind;
        file_wr_addr_d = file_wr_en_d ? file_addr : file_wr_addr_q;
        file_wr_data_d = file_wr_en_d ? result : file_wr_data_q;
        // Window has no storage; its write lands at the pointed location
        mem_wr_en_d = writes && !is_load && dest_sel == `BOI_DEST_FILE && is_ind;
        mem_wr_addr_d = mem_wr_en_d ? pif.eff_addr : mem_wr_addr_q;
        mem_wr_data_d = mem_wr_en_d ? result : mem_wr_data_q;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            acc_q <= `BOI_BYTE_RST;
            zero_q <= `BOI_FLAG_RST;
            carry_q <= `BOI_FLAG_RST;
            file_wr_en_q <= `BOI_FLAG_RST;
            file_wr_addr_q <= `BOI_FILE_ADDR_RST;
            file_wr_data_q <= `BOI_BYTE_RST;
            mem_wr_en_q <= `BOI_FLAG_RST;
            mem_wr_addr_q <= `BOI_PTR_RST;
            mem_wr_data_q <= `BOI_BYTE_RST;
            done_q <= `BOI_FLAG_RST;
        end else begin
            acc_q <= acc_d_v;
            zero_q <= zero_d;
            carry_q <= carry_d;
            file_wr_en_q <= file_wr_en_d;
            file_wr_addr_q <= file_wr_addr_d;
            file_wr_data_q <= file_wr_data_d;
            mem_wr_en_q <= mem_wr_en_d;
            mem_wr_addr_q <= mem_wr_addr_d;
            mem_wr_data_q <= mem_wr_data_d;
            done_q <= writes;
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    inc_to_acc_a: assert property (
        op_valid && op_code == BOI_OP_ADD_ONE_TO_OPERAND && !dest_sel && !is_ind |=>
            acc_q == 8'($past(file_rd_data) + `BOI_BYTE_ONE) && zero_q == (acc_q == `BOI_BYTE_RST))
        else $error("Increment result wrong");

    dest_file_a: assert property (
        op_valid && !is_load && op_code != BOI_OP_IDLE && dest_sel && !is_ind |=>
            file_wr_en_q && file_wr_addr_q == $past(file_addr) && $stable(acc_q))
        else $error("File destination not written");

    or_keeps_carry_a: assert property (
        op_valid && op_code == BOI_OP_BITWISE_OR_ACCUMULATOR_OPERAND |=>
            carry_q == $past(carry_q) && zero_q == (($past(acc_q) | $past(operand)) == `BOI_BYTE_RST))
        else $error("OR flags wrong");

    shl_carry_a: assert property (
        op_valid && op_code == BOI_OP_SHIFT_LEFT_LOGICAL && !dest_sel |=>
            carry_q == $past(operand[7]) && acc_q == {$past(operand[6:0]), 1'b0})
        else $error("Left shift wrong");

    shr_carry_a: assert property (
        op_valid && op_code == BOI_OP_SHIFT_RIGHT_LOGICAL && !dest_sel |=>
            carry_q == $past(operand[0]) && acc_q == {1'b0, $past(operand[7:1])})
        else $error("Right shift wrong");

    copy_zero_a: assert property (
        op_valid && op_code == BOI_OP_COPY_OPERAND |=> zero_q == ($past(operand) == `BOI_BYTE_RST))
        else $error("Copy zero flag wrong");

    load_acc_a: assert property (
        op_valid && is_load |=> acc_q == $past(mem_rd_data) && !file_wr_en_q && !mem_wr_en_q)
        else $error("Pointer load wrong");

    window_redirect_a: assert property (
        op_valid && !is_load && op_code != BOI_OP_IDLE && dest_sel && is_ind |=>
            mem_wr_en_q && !file_wr_en_q && mem_wr_addr_q == $past(mem_rd_addr))
        else $error("Window write not redirected");

    one_cycle_a: assert property (
        op_valid && op_code != BOI_OP_IDLE |=> done_q ##1 (done_q == $past(op_valid && op_code != BOI_OP_IDLE)))
        else $error("Operation not committed in one cycle");

endmodule : boi_exec

`default_nettype wire

// ---- tb/boi_exec_tb.sv ----
`timescale 1ns/1ps
`default_nettype none

module boi_exec_tb;
import boi_pkg::*;

// ----------------------------------------
// Signals
// ----------------------------------------
localparam int N_OPS = 3000;
logic clk, rst_n, op_valid, dest_sel, ptr_sel, rel_mode, ptr_load_en, ptr_load_sel;
boi_op_t op_code;
logic [6:0] file_addr, file_wr_addr_q;
logic [1:0] pointer_update_select;
logic [5:0] rel_offset;
logic [7:0] file_rd_data, mem_rd_data, file_wr_data_q, mem_wr_data_q, acc_q;
boi_ptr_t ptr_load_val, mem_rd_addr, mem_wr_addr_q, ptr0_q, ptr1_q;
logic file_wr_en_q, mem_wr_en_q, zero_q, carry_q, done_q;
integer seed = 32'h89aa;
int err_total = 0;
int checks = 0;
// Expected state, kept by the bench model
logic [7:0] e_acc, e_fd, e_md;
logic e_z, e_c, e_fwe, e_mwe, e_done;
logic [6:0] e_fa;
boi_ptr_t e_ma;
boi_ptr_t e_ptr [2];

// Memory answers with a pattern of its address, so a wrong address shows as wrong data
function automatic logic [7:0] mem_fn(boi_ptr_t a);
    return a[7:0] ^ a[15:8] ^ 8'h5A;
endfunction : mem_fn
assign mem_rd_data = mem_fn(mem_rd_addr);

boi_exec dut (.clk, .rst_n, .op_valid, .op_code, .file_addr, .dest_sel, .ptr_sel, .pointer_update_select,
    .rel_mode, .rel_offset, .file_rd_data, .mem_rd_data, .ptr_load_en, .ptr_load_sel, .ptr_load_val,
    .mem_rd_addr, .file_wr_en_q, .file_wr_addr_q, .file_wr_data_q, .mem_wr_en_q, .mem_wr_addr_q,
    .mem_wr_data_q, .acc_q, .zero_q, .carry_q, .ptr0_q, .ptr1_q, .done_q);

initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
end

// ----------------------------------------
// Compare and report
// ----------------------------------------
task automatic chk_bit(string nm, logic exp, logic got);
    checks++;
    if (got !== exp) begin
        err_total++;
        $display("ERROR %s expected %b seen %b", nm, exp, got);
    end
endtask : chk_bit

task automatic chk_val(string nm, logic [15:0] exp, logic [15:0] got);
    checks++;
    if (got !== exp) begin
        err_total++;
        $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
endtask : chk_val

task automatic report_and_stop();
    if (err_total == 0 && checks > 0) begin
        $display("Test passed");
    end else begin
        $display("Test failed");
    end
    $finish;
endtask : report_and_stop

task automatic cmp_all();
    chk_val("acc_q", 16'(e_acc), 16'(acc_q));
    chk_bit("zero_q", e_z, zero_q);
    chk_bit("carry_q", e_c, carry_q);
    chk_val("ptr0_q", e_ptr[0], ptr0_q);
    chk_val("ptr1_q", e_ptr[1], ptr1_q);
    chk_bit("done_q", e_done, done_q);
    chk_bit("file_wr_en_q", e_fwe, file_wr_en_q);
    chk_bit("mem_wr_en_q", e_mwe, mem_wr_en_q);
    if (e_fwe) begin
        chk_val("file_wr_addr_q", 16'(e_fa), 16'(file_wr_addr_q));
        chk_val("file_wr_data_q", 16'(e_fd), 16'(file_wr_data_q));
    end
    if (e_mwe) begin
        chk_val("mem_wr_addr_q", e_ma, mem_wr_addr_q);
        chk_val("mem_wr_data_q", 16'(e_md), 16'(mem_wr_data_q));
    end
endtask : cmp_all

// ----------------------------------------
// One random instruction and its expected effect
// ----------------------------------------
task automatic step();
    logic [31:0] r;
    logic win;
    logic [7:0] opd, res;
    boi_ptr_t p, ea;
    boi_ptr_t nxt [2];
    r = $random(seed);
    // Corner values are weighted in: windows, extreme offsets, wrap-prone pointers
    op_valid = (r[3:0] != 4'h0);
    op_code = boi_op_t'(3'($unsigned($random(seed)) % 7));
    file_addr = (r[5:4] == 2'b00) ? {6'h00, r[6]} : 7'($random(seed));
    dest_sel = r[7];
    ptr_sel = r[8];
    pointer_update_select = r[10:9];
    rel_mode = r[11] & r[12];
    rel_offset = (r[14:13] == 2'b00) ? 6'h20 : (r[14:13] == 2'b01) ? 6'h1F : r[20:15];
    file_rd_data = (r[22:21] == 2'b00) ? 8'h00 : (r[22:21] == 2'b01) ? 8'hFF : 8'($random(seed));
    ptr_load_en = (r[25:23] == 3'h0);
    ptr_load_sel = r[26];
    ptr_load_val = (r[28:27] == 2'b00) ? 16'hFFFF : (r[28:27] == 2'b01) ? 16'h0000 : 16'($random(seed));
    #1;
    e_fwe = 1'b0;
    e_mwe = 1'b0;
    e_done = op_valid && (op_code != BOI_OP_IDLE);
    win = (file_addr[6:1] == 6'h00);
    p = e_ptr[ptr_sel];
    nxt = e_ptr;
    if (e_done && op_code == BOI_OP_LOAD_VIA_POINTER) begin
        ea = p;
        if (rel_mode) begin
            ea = p + {{10{rel_offset[5]}}, rel_offset};
        end else begin
            case (pointer_update_select)
                2'b00: begin
                    ea = p + 16'h0001;
                    nxt[ptr_sel] = p + 16'h0001;
                end
                2'b01: begin
                    ea = p - 16'h0001;
                    nxt[ptr_sel] = p - 16'h0001;
                end
                2'b10: nxt[ptr_sel] = p + 16'h0001;
                default: nxt[ptr_sel] = p - 16'h0001;
            endcase
        end
        chk_val("mem_rd_addr", ea, mem_rd_addr);
        e_acc = mem_fn(ea);
        e_z = (e_acc == 8'h00);
    end else if (e_done) begin
        opd = win ? mem_fn(e_ptr[file_addr[0]]) : file_rd_data;
        if (win) chk_val("mem_rd_addr", e_ptr[file_addr[0]], mem_rd_addr);
        case (op_code)
            BOI_OP_ADD_ONE_TO_OPERAND: res = opd + 8'h01;
            BOI_OP_BITWISE_OR_ACCUMULATOR_OPERAND: res = e_acc | opd;
            BOI_OP_SHIFT_LEFT_LOGICAL: begin
                res = {opd[6:0], 1'b0};
                e_c = opd[7];
            end
            BOI_OP_SHIFT_RIGHT_LOGICAL: begin
                res = {1'b0, opd[7:1]};
                e_c = opd[0];
            end
            default: res = opd;
        endcase
        e_z = (res == 8'h00);
        if (!dest_sel) begin
            e_acc = res;
        end else if (win) begin
            e_mwe = 1'b1;
            e_ma = e_ptr[file_addr[0]];
            e_md = res;
        end else begin
            e_fwe = 1'b1;
            e_fa = file_addr;
            e_fd = res;
        end
    end
    // Direct load beats the automatic update of the same pointer
    if (ptr_load_en) nxt[ptr_load_sel] = ptr_load_val;
    e_ptr = nxt;
endtask : step

// ----------------------------------------
// Main sequence and watchdog
// ----------------------------------------
initial begin
    rst_n = 1'b0;
    op_valid = 1'b0;
    op_code = BOI_OP_IDLE;
    {file_addr, dest_sel, ptr_sel, pointer_update_select, rel_mode, rel_offset} = '0;
    {file_rd_data, ptr_load_en, ptr_load_sel, ptr_load_val} = '0;
    {e_acc, e_z, e_c, e_fwe, e_mwe, e_done, e_fa, e_fd, e_md, e_ma} = '0;
    e_ptr[0] = 16'h0000;
    e_ptr[1] = 16'h0000;
    repeat (16) @(negedge clk);
    rst_n = 1'b1;
    for (int i = 0; i < N_OPS; i++) begin
        cmp_all();
        // Mid-run reset must clear state built up by earlier ops
        if (i == N_OPS / 2) begin
            rst_n = 1'b0;
            op_valid = 1'b0;
            ptr_load_en = 1'b0;
            repeat (2) @(negedge clk);
            rst_n = 1'b1;
            {e_acc, e_z, e_c, e_fwe, e_mwe, e_done} = '0;
            e_ptr[0] = 16'h0000;
            e_ptr[1] = 16'h0000;
            cmp_all();
        end
        step();
        @(negedge clk);
    end
    cmp_all();
    report_and_stop();
end

initial begin
    #((N_OPS + 64) * 16);
    err_total++;
    report_and_stop();
end

endmodule : boi_exec_tb

`default_nettype wire
